// >>> hw/lbpc_pkg.sv
package lbpc_pkg;
  // sfr addresses on the core's internal bus
  localparam logic [7:0] ADDR_DISPLAY_CONFIG = 8'h95;
  localparam logic [7:0] ADDR_PIN_SELECT_LOW = 8'h97;
  localparam logic [7:0] ADDR_VOLTAGE_CONFIG = 8'h9c;
  localparam logic [7:0] ADDR_SEG_POINTER = 8'hac;
  localparam logic [7:0] ADDR_SEG_DATA = 8'hae;
  localparam logic [7:0] ADDR_FREEZE_CONFIG = 8'hb1;
  localparam logic [7:0] ADDR_PIN_SELECT_HIGH = 8'hed;
  // field positions
  localparam int DISPLAY_ON_BIT = 7;
  localparam int LOW_POWER_OFF_BIT = 6;
  localparam int MUX_LSB = 0;
  localparam int LADDER_SELECT_BIT = 6;
  localparam int BIAS_LSB = 0;
  localparam int BIAS_W = 6;
  localparam int FREEZE_BIT = 0;
  localparam int PTR_WRITE_BIT = 7;
  // reset values
  localparam logic [7:0] RST_DISPLAY_CONFIG = 8'h00;
  localparam logic [7:0] RST_VOLTAGE_CONFIG = 8'h00;
  localparam logic [7:0] RST_PIN_SELECT = 8'h00;
  localparam logic [7:0] RST_FREEZE_CONFIG = 8'h00;
  // segment memory geometry
  localparam int SEG_BYTES = 15;
  localparam int SEG_LINES = 29;
  localparam int FIXED_SEGS = 16;
  localparam int OPT_SEGS = 13;
  localparam logic [1:0] MUX_FOUR = 2'h3;
  // first shared pin index: common_line_three on 27, common_line_two on 28
  localparam int SHARED_COMMON_LINE_THREE_SEG = 27;
  localparam int SHARED_COMMON_LINE_TWO_SEG = 28;
endpackage : lbpc_pkg

// >>> hw/lbpc_seg_mem.sv
`timescale 1ns/1ps
`default_nettype none
module lbpc_seg_mem
  import lbpc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wr_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  output logic [SEG_BYTES*8-1:0] image_o
);
  logic [7:0] mem_r [SEG_BYTES];
  logic in_range;

  assign in_range = (addr_i < 4'(SEG_BYTES));
  assign rdata_o = in_range ? mem_r[addr_i] : 8'h00;

  // memory is only touched by reset and explicit pointer writes, never by display on/off
  genvar g;
  generate
    for (g = 0; g < SEG_BYTES; g++) begin : g_byte
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          mem_r[g] <= 8'h00;
        end else if (wr_i && addr_i == 4'(g)) begin
          mem_r[g] <= wdata_i;
        end
      end
      assign image_o[g*8 +: 8] = mem_r[g];
    end
  endgenerate
endmodule : lbpc_seg_mem
`default_nettype wire

// >>> hw/lbpc_top.sv
`timescale 1ns/1ps
`default_nettype none
module lbpc_top
  import lbpc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  output logic sfr_hit_o,
  input wire logic battery_power_mode_i,
  input wire logic reference_in_battery_enable_i,
  output logic display_active_o,
  output logic charge_pump_enable_o,
  output logic ladder_select_o,
  output logic [BIAS_W-1:0] bias_level_select_o,
  output logic [1:0] mux_mode_o,
  output logic [SEG_LINES-1:0] segment_pin_enable_o,
  output logic common_line_two_en_o,
  output logic common_line_three_en_o,
  output logic [SEG_BYTES*8-1:0] display_image_o
);
  logic [7:0] display_config_r;
  logic [7:0] voltage_config_r;
  logic [7:0] pin_select_low_r;
  logic [7:0] pin_select_high_r;
  logic [7:0] freeze_config_r;
  logic [7:0] seg_pointer_r;
  logic [7:0] seg_data_r;
  logic [7:0] seg_data_nxt;
  logic [BIAS_W-1:0] bias_level_r;
  logic [SEG_BYTES*8-1:0] shown_image_r;
  logic [SEG_BYTES*8-1:0] live_image;
  logic [7:0] mem_rdata;

  // address decode
  logic wr_dcfg, wr_vcfg, wr_psl, wr_psh, wr_frz, wr_ptr, wr_dat;
  assign wr_dcfg = sfr_wr_i && sfr_addr_i == ADDR_DISPLAY_CONFIG;
  assign wr_vcfg = sfr_wr_i && sfr_addr_i == ADDR_VOLTAGE_CONFIG;
  assign wr_psl = sfr_wr_i && sfr_addr_i == ADDR_PIN_SELECT_LOW;
  assign wr_psh = sfr_wr_i && sfr_addr_i == ADDR_PIN_SELECT_HIGH;
  assign wr_frz = sfr_wr_i && sfr_addr_i == ADDR_FREEZE_CONFIG;
  assign wr_ptr = sfr_wr_i && sfr_addr_i == ADDR_SEG_POINTER;
  assign wr_dat = sfr_wr_i && sfr_addr_i == ADDR_SEG_DATA;

  // pointer write with msb set copies data into memory
  logic mem_wr;
  assign mem_wr = wr_ptr && sfr_wdata_i[PTR_WRITE_BIT];

  lbpc_seg_mem u_mem (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(mem_wr),
    .addr_i(sfr_wdata_i[3:0]),
    .wdata_i(seg_data_r),
    .rdata_o(mem_rdata),
    .image_o(live_image)
  );

  // configuration registers; display on/off never clears them
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      display_config_r <= RST_DISPLAY_CONFIG;
      voltage_config_r <= RST_VOLTAGE_CONFIG;
      pin_select_low_r <= RST_PIN_SELECT;
      pin_select_high_r <= RST_PIN_SELECT;
      freeze_config_r <= RST_FREEZE_CONFIG;
      seg_pointer_r <= 8'h00;
    end else begin
      if (wr_dcfg) display_config_r <= sfr_wdata_i;
      if (wr_vcfg) voltage_config_r <= sfr_wdata_i;
      if (wr_psl) pin_select_low_r <= sfr_wdata_i;
      if (wr_psh) pin_select_high_r <= sfr_wdata_i;
      if (wr_frz) freeze_config_r <= sfr_wdata_i;
      if (wr_ptr) seg_pointer_r <= sfr_wdata_i;
    end
  end

  // data register: sfr write, or a read-back load from memory on pointer write with msb clear
  always_comb begin
    seg_data_nxt = seg_data_r;
    if (wr_dat) seg_data_nxt = sfr_wdata_i;
    if (wr_ptr && !sfr_wdata_i[PTR_WRITE_BIT]) seg_data_nxt = mem_rdata;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) seg_data_r <= 8'h00;
    else seg_data_r <= seg_data_nxt;
  end

  // freeze: panel keeps the last image while software rewrites memory
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) shown_image_r <= '0;
    else if (!freeze_config_r[FREEZE_BIT]) shown_image_r <= live_image;
  end
  assign display_image_o = shown_image_r;

  // bias level feeds only the pump reference, so a change needs no frame restart
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) bias_level_r <= '0;
    else bias_level_r <= voltage_config_r[BIAS_LSB +: BIAS_W];
  end

  // display state
  logic enable_bit, low_power_off, display_active;
  assign enable_bit = display_config_r[DISPLAY_ON_BIT];
  assign low_power_off = display_config_r[LOW_POWER_OFF_BIT];
  assign display_active = enable_bit && !(battery_power_mode_i && low_power_off);
  assign display_active_o = display_active;

  // ladder mode: pump and compensation both idle; in battery mode the pump
  // also needs the reference, which software must keep on
  assign ladder_select_o = voltage_config_r[LADDER_SELECT_BIT];
  assign charge_pump_enable_o = display_active && !ladder_select_o
                                && (!battery_power_mode_i || reference_in_battery_enable_i);
  assign bias_level_select_o = ladder_select_o ? '0 : bias_level_r;

  // pin assignment
  logic four_way;
  assign mux_mode_o = display_config_r[MUX_LSB +: 2];
  assign four_way = (mux_mode_o == MUX_FOUR);
  assign common_line_two_en_o = four_way;
  assign common_line_three_en_o = four_way;

  logic [OPT_SEGS-1:0] opt_sel;
  assign opt_sel = {pin_select_high_r[4:0], pin_select_low_r};
  genvar s;
  generate
    for (s = 0; s < SEG_LINES; s++) begin : g_pin
      if (s < FIXED_SEGS) begin : g_fixed
        assign segment_pin_enable_o[s] = 1'b1;
      end else if (s == SHARED_COMMON_LINE_THREE_SEG || s == SHARED_COMMON_LINE_TWO_SEG) begin : g_shared
        assign segment_pin_enable_o[s] = opt_sel[s-FIXED_SEGS] && !four_way;
      end else begin : g_opt
        assign segment_pin_enable_o[s] = opt_sel[s-FIXED_SEGS];
      end
    end
  endgenerate

  // read mux; unmapped addresses read zero with hit low
  logic [7:0] rd_mux;
  logic hit;
  always_comb begin
    rd_mux = 8'h00;
    hit = 1'b1;
    unique case (sfr_addr_i)
      ADDR_DISPLAY_CONFIG: rd_mux = display_config_r;
      ADDR_VOLTAGE_CONFIG: rd_mux = voltage_config_r;
      ADDR_PIN_SELECT_LOW: rd_mux = pin_select_low_r;
      ADDR_PIN_SELECT_HIGH: rd_mux = pin_select_high_r;
      ADDR_FREEZE_CONFIG: rd_mux = freeze_config_r;
      ADDR_SEG_POINTER: rd_mux = seg_pointer_r;
      ADDR_SEG_DATA: rd_mux = seg_data_r;
      default: hit = 1'b0;
    endcase
  end
  assign sfr_rdata_o = sfr_rd_i ? rd_mux : 8'h00;
  assign sfr_hit_o = (sfr_rd_i || sfr_wr_i) && hit;
endmodule : lbpc_top
`default_nettype wire

// >>> testbench/lbpc_properties.sv
`timescale 1ns/1ps
`default_nettype none
module lbpc_chk
  import lbpc_pkg::*;
(
  input wire logic clk_i, rst_i, sfr_wr_i, battery_power_mode_i,
  input wire logic [7:0] sfr_addr_i, sfr_wdata_i,
  input wire logic display_active_o, charge_pump_enable_o, ladder_select_o,
  input wire logic [BIAS_W-1:0] bias_level_select_o,
  input wire logic [1:0] mux_mode_o,
  input wire logic [SEG_LINES-1:0] segment_pin_enable_o,
  input wire logic common_line_two_en_o, common_line_three_en_o,
  input wire logic [SEG_BYTES*8-1:0] display_image_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // write decodes, kept as plain wires so the properties stay readable
  wire logic w_cfg = sfr_wr_i && sfr_addr_i == ADDR_DISPLAY_CONFIG;
  wire logic w_volt = sfr_wr_i && sfr_addr_i == ADDR_VOLTAGE_CONFIG;
  wire logic w_low = sfr_wr_i && sfr_addr_i == ADDR_PIN_SELECT_LOW;
  wire logic w_frz = sfr_wr_i && sfr_addr_i == ADDR_FREEZE_CONFIG;
  // freeze bit as last written, rebuilt from the bus because the checker sees no internals
  logic frz_held;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      frz_held <= 1'b0;
    end else if (w_frz) begin
      frz_held <= sfr_wdata_i[FREEZE_BIT];
    end
  end
  // bias output lags the register by one cycle, so a lone write is needed
  sequence s_volt_wr; w_volt ##1 !w_volt; endsequence
  // a frozen edge followed by its sample: a clear written meanwhile cannot trip it
  sequence s_frz_on; frz_held ##1 1'b1; endsequence
  property p_bias;
    s_volt_wr |=> bias_level_select_o ==
      ($past(sfr_wdata_i[LADDER_SELECT_BIT], 2) ? 6'h00 : $past(sfr_wdata_i[BIAS_W-1:0], 2));
  endproperty
  property p_ladder; w_volt |=> ladder_select_o == $past(sfr_wdata_i[LADDER_SELECT_BIT]); endproperty
  property p_ladder_bias; ladder_select_o [*2] |-> bias_level_select_o == 6'h00; endproperty
  property p_on;
    w_cfg |=> display_active_o ==
      ($past(sfr_wdata_i[DISPLAY_ON_BIT]) && !(battery_power_mode_i && $past(sfr_wdata_i[LOW_POWER_OFF_BIT])));
  endproperty
  property p_pump; charge_pump_enable_o |-> display_active_o && !ladder_select_o; endproperty
  property p_fixed; segment_pin_enable_o[15:0] == 16'hffff; endproperty
  property p_low; w_low |=> segment_pin_enable_o[23:16] == $past(sfr_wdata_i); endproperty
  property p_four;
    mux_mode_o == MUX_FOUR |-> segment_pin_enable_o[28:27] == 2'b00
      && common_line_two_en_o && common_line_three_en_o;
  endproperty
  property p_freeze; s_frz_on |-> $stable(display_image_o); endproperty
  a_bias: assert property (p_bias) else $error("bias level wrong");
  a_ladder: assert property (p_ladder) else $error("ladder select wrong");
  a_ladder_bias: assert property (p_ladder_bias) else $error("bias not zero in ladder mode");
  a_on: assert property (p_on) else $error("display active wrong");
  a_pump: assert property (p_pump) else $error("pump on while dark or ladder");
  a_fixed: assert property (p_fixed) else $error("fixed segment pin off");
  a_low: assert property (p_low) else $error("low pin enables wrong");
  a_four: assert property (p_four) else $error("shared pins not commons");
  a_freeze: assert property (p_freeze) else $error("image moved while frozen");
endmodule : lbpc_chk
bind lbpc_top lbpc_chk i_chk (.*);
`default_nettype wire

// >>> testbench/lbpc_glass.sv
`timescale 1ns/1ps
`default_nettype none
module lbpc_glass
  import lbpc_pkg::*;
(
  input wire logic display_active_i,
  input wire logic [SEG_BYTES*8-1:0] image_i,
  output logic [SEG_BYTES*8-1:0] seen_o
);
  // passive panel: undriven glass relaxes to blank, it never holds a pattern
  assign seen_o = display_active_i ? image_i : '0;
endmodule : lbpc_glass
`default_nettype wire

// >>> testbench/lbpc_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module lbpc_tb_top
  import lbpc_pkg::*;
;
  logic clk_i = 0, rst_i = 1, wr = 0, rd = 0, bat = 0, ref_en = 0, act, pump, lad, c2, c3, hit;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [5:0] bias;
  logic [1:0] mux;
  logic [28:0] pins;
  logic [119:0] img, seen;
  int num_errors = 0, comparisons = 0;
  lbpc_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_addr_i(addr),
    .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .sfr_hit_o(hit), .battery_power_mode_i(bat),
    .reference_in_battery_enable_i(ref_en), .display_active_o(act), .charge_pump_enable_o(pump),
    .ladder_select_o(lad), .bias_level_select_o(bias), .mux_mode_o(mux), .segment_pin_enable_o(pins),
    .common_line_two_en_o(c2), .common_line_three_en_o(c3), .display_image_o(img));
  lbpc_glass i_glass (.display_active_i(act), .image_i(img), .seen_o(seen));
  initial forever #12.5 clk_i = ~clk_i;
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  // one idle edge after each write keeps the strobe from being set twice in a step
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask : wr_reg
  // read data and hit are combinational; both are taken at the edge that ends the access
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e, input logic eh);
    @(posedge clk_i);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_i);
    chk(rdata, e);
    chk(hit, eh);
    rd <= 1'b0;
  endtask : rd_reg
  // three edges cover the longest path: pointer write, memory, shown image
  task automatic settle;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
  endtask : settle
  task automatic t_reset;
    rd_reg(ADDR_DISPLAY_CONFIG, RST_DISPLAY_CONFIG, 1'b1);
    rd_reg(ADDR_VOLTAGE_CONFIG, RST_VOLTAGE_CONFIG, 1'b1);
    rd_reg(ADDR_PIN_SELECT_HIGH, RST_PIN_SELECT, 1'b1);
    rd_reg(8'h96, 8'h00, 1'b0); // unmapped: reads zero, no hit
    @(negedge clk_i);
    chk(lad, 1'b0);
    chk(pump, 1'b0);
    chk(pins, {13'h0000, 16'hffff});
  endtask : t_reset
  task automatic t_volt;
    wr_reg(ADDR_VOLTAGE_CONFIG, 8'h3f);
    settle;
    chk(bias, 6'h3f);
    wr_reg(ADDR_VOLTAGE_CONFIG, 8'h25);
    settle;
    chk(bias, 6'h25);
    wr_reg(ADDR_VOLTAGE_CONFIG, 8'h7f);
    settle;
    chk({lad, bias}, 7'h40);
    wr_reg(ADDR_VOLTAGE_CONFIG, 8'h00);
  endtask : t_volt
  task automatic t_power;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_i);
      bat <= i[3];
      ref_en <= i[2];
      wr_reg(ADDR_DISPLAY_CONFIG, {i[1], i[0], 6'h00});
      settle;
      chk(act, i[1] && !(i[3] && i[0]));
      chk(pump, i[1] && !(i[3] && i[0]) && (!i[3] || i[2]));
    end
  endtask : t_power
  task automatic t_pins;
    wr_reg(ADDR_PIN_SELECT_LOW, 8'h3c);
    wr_reg(ADDR_PIN_SELECT_HIGH, 8'h0f);
    wr_reg(ADDR_DISPLAY_CONFIG, 8'h83);
    settle;
    chk(pins, {2'b00, 3'b111, 8'h3c, 16'hffff});
    chk({c2, c3, mux}, 4'hf);
    wr_reg(ADDR_DISPLAY_CONFIG, 8'h80);
    settle;
    chk(pins, {5'h0f, 8'h3c, 16'hffff});
    chk({c2, c3}, 2'b00);
  endtask : t_pins
  task automatic t_mem;
    wr_reg(ADDR_FREEZE_CONFIG, 8'h01);
    wr_reg(ADDR_SEG_DATA, 8'hf0);
    wr_reg(ADDR_SEG_POINTER, 8'h8d);
    settle;
    chk(img[13*8+:8], 8'h00);
    wr_reg(ADDR_FREEZE_CONFIG, 8'h00);
    settle;
    chk(seen[13*8+:8], 8'hf0);
    wr_reg(ADDR_SEG_DATA, 8'h00);
    wr_reg(ADDR_SEG_POINTER, 8'h0d);
    rd_reg(ADDR_SEG_DATA, 8'hf0, 1'b1);
    wr_reg(ADDR_DISPLAY_CONFIG, 8'h00);
    settle;
    chk({act, img[13*8+:8]}, 9'h0f0);
    rd_reg(ADDR_PIN_SELECT_LOW, 8'h3c, 1'b1);
  endtask : t_mem
  task automatic report_and_stop;
    if (num_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_volt;
    t_power;
    t_pins;
    t_mem;
    report_and_stop;
  end
  // the whole run needs under two hundred cycles; a hang runs on to this limit and fails
  initial begin
    repeat (3000) @(posedge clk_i);
    num_errors++;
    report_and_stop;
  end
endmodule : lbpc_tb_top
`default_nettype wire
